// ---- inc/olgc_defs.vh ----
// Purpose: constants for the loopback, power and LED control registers
// Assumes: 8-bit register port, byte addresses as printed
// Notes: definitions only
`ifndef OLGC_DEFS_VH
`define OLGC_DEFS_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define OLGC_ADDR_FTCB 8'h0a
`define OLGC_ADDR_LPLC 8'h0b

// ------------------------------------------------------------------
// field positions in loopback_power_led_control
// ------------------------------------------------------------------
`define OLGC_BIT_PWR 6
`define OLGC_BIT_ERRDROP 5
`define OLGC_BIT_TEST 4
`define OLGC_BIT_POS_HI 3
`define OLGC_BIT_POS_LO 2
`define OLGC_BIT_LED 1

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define OLGC_FTCB_RST 8'h24
`define OLGC_PWR_RST 1'b0
`define OLGC_TEST_RST 1'b0
`define OLGC_POS_HI_RST 1'b1
`define OLGC_LED_RST 1'b0
`define OLGC_STRAP_RST 1'b0

// ------------------------------------------------------------------
// loopback position encoding
// ------------------------------------------------------------------
`define OLGC_POS_PORT2_MAC 2'b10

`endif

// ---- rtl/olgc_strap.v ----
// Purpose: capture strap pin levels once, at the release of reset
// Assumes: strap pins are stable around the reset release
// Notes: flops reset to constants, pins are taken at the first edge
`timescale 1ns/1ps
`include "olgc_defs.vh"

module olgc_strap (
   input wire clk_sys,
   input wire rst_n,
   input wire error_drop_strap_pin,
   input wire loopback_position_strap_pin,
   input wire led_select_high_strap_pin,
   output reg error_drop_strap_r,
   output reg loopback_low_strap_r,
   output reg led_high_strap_r,
   output reg strap_load_r
);

   reg captured_r;

   // ---------------------------------------------------------------
   // one-shot capture
   // ---------------------------------------------------------------
   // an async reset may only load constants, so the pins are sampled
   // by the clock at the first edge after release
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         captured_r <= 1'b0;
         strap_load_r <= 1'b0;
         error_drop_strap_r <= `OLGC_STRAP_RST;
         loopback_low_strap_r <= `OLGC_STRAP_RST;
         led_high_strap_r <= `OLGC_STRAP_RST;
      end else begin
         strap_load_r <= 1'b0;
         if (!captured_r) begin
            captured_r <= 1'b1;
            strap_load_r <= 1'b1;
            error_drop_strap_r <= error_drop_strap_pin; // R10
            loopback_low_strap_r <= loopback_position_strap_pin;
            led_high_strap_r <= led_select_high_strap_pin; // R9
         end
      end
   end

endmodule // olgc_strap

// ---- rtl/olgc_top.v ----
// Purpose: loopback, Phy_low_power_enable and LED select control registers
// Assumes: register port is the internal side of the serial interface
// Notes: also makes the per-frame loop or drop decision
`timescale 1ns/1ps
`include "olgc_defs.vh"

// Function
// R1: phy_low_power_enable follows the power-save bit, which resets to 0.
// R2: with error drop set, maintenance and bad-CRC/short/long frames drop.
// R3: with error drop set, only good, valid-length frames are looped.
// R4: with error drop clear, only maintenance frames drop, others loop.
// R5: position field 10 places the loopback at the second port's MAC.
// R6: software must not write position codes 00, 01 or 11.
// R7: software must write 0 to the test-mode bit, which resets to 0.
// R8: the LED mode bit drives only the low LED select.
// R9: the high LED select comes from a strap pin, no write changes it.
// R10: the error-drop bit loads from its strap pin at reset.
module olgc_top (
   input wire clk_sys,
   input wire rst_n,
   input wire reg_wr_en,
   input wire reg_rd_en,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   input wire error_drop_strap_pin,
   input wire loopback_position_strap_pin,
   input wire led_select_high_strap_pin,
   input wire frame_end,
   input wire frame_is_oam,
   input wire frame_crc_err,
   input wire frame_undersize,
   input wire frame_oversize,
   output reg frame_loop,
   output reg frame_drop,
   output reg phy_low_power_enable,
   output reg error_drop_enable,
   output reg test_mode,
   output reg [1:0] loopback_position_select,
   output reg loopback_at_port2_mac,
   output reg led_select_low,
   output reg led_select_high,
   output reg [7:0] factory_test_b
);

   wire error_drop_strap;
   wire loopback_low_strap;
   wire led_high_strap;
   wire strap_load;

   reg [7:0] factory_test_b_nxt;
   reg phy_low_power_enable_nxt;
   reg error_drop_enable_nxt;
   reg test_mode_nxt;
   reg [1:0] loopback_position_select_nxt;
   reg led_select_low_nxt;
   reg led_select_high_nxt;
   reg [7:0] reg_rdata_nxt;
   reg frame_bad;

   // ---------------------------------------------------------------
   // strap capture
   // ---------------------------------------------------------------
   olgc_strap u_strap (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .error_drop_strap_pin(error_drop_strap_pin),
      .loopback_position_strap_pin(loopback_position_strap_pin),
      .led_select_high_strap_pin(led_select_high_strap_pin),
      .error_drop_strap_r(error_drop_strap),
      .loopback_low_strap_r(loopback_low_strap),
      .led_high_strap_r(led_high_strap),
      .strap_load_r(strap_load)
   );

   // ---------------------------------------------------------------
   // register write path
   // ---------------------------------------------------------------
   always @* begin
      factory_test_b_nxt = factory_test_b;
      phy_low_power_enable_nxt = phy_low_power_enable;
      error_drop_enable_nxt = error_drop_enable;
      test_mode_nxt = test_mode;
      loopback_position_select_nxt = loopback_position_select;
      led_select_low_nxt = led_select_low;
      led_select_high_nxt = led_select_high;
      if (strap_load) begin
         // strap load wins over a write landing on the same edge
         error_drop_enable_nxt = error_drop_strap; // R10
         loopback_position_select_nxt = {`OLGC_POS_HI_RST,
                                         loopback_low_strap};
         led_select_high_nxt = led_high_strap; // R9
      end else if (reg_wr_en) begin
         case (reg_addr)
            `OLGC_ADDR_FTCB: begin
               factory_test_b_nxt = reg_wdata;
            end
            `OLGC_ADDR_LPLC: begin
               phy_low_power_enable_nxt = reg_wdata[`OLGC_BIT_PWR]; // R1
               error_drop_enable_nxt = reg_wdata[`OLGC_BIT_ERRDROP];
               // stored as written; keeping it 0 is software's job
               test_mode_nxt = reg_wdata[`OLGC_BIT_TEST]; // R7
               // reserved codes are stored too, no defined effect
               loopback_position_select_nxt =
                  reg_wdata[`OLGC_BIT_POS_HI:`OLGC_BIT_POS_LO]; // R6
               led_select_low_nxt = reg_wdata[`OLGC_BIT_LED]; // R8
            end
            default: begin
               factory_test_b_nxt = factory_test_b;
            end
         endcase
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         factory_test_b <= `OLGC_FTCB_RST;
         phy_low_power_enable <= `OLGC_PWR_RST; // R1
         error_drop_enable <= `OLGC_STRAP_RST;
         test_mode <= `OLGC_TEST_RST; // R7
         loopback_position_select <= {`OLGC_POS_HI_RST, `OLGC_STRAP_RST};
         loopback_at_port2_mac <= 1'b0;
         led_select_low <= `OLGC_LED_RST;
         led_select_high <= `OLGC_STRAP_RST;
      end else begin
         factory_test_b <= factory_test_b_nxt;
         phy_low_power_enable <= phy_low_power_enable_nxt; // R1
         error_drop_enable <= error_drop_enable_nxt;
         test_mode <= test_mode_nxt;
         loopback_position_select <= loopback_position_select_nxt;
         loopback_at_port2_mac <= (loopback_position_select_nxt ==
                                   `OLGC_POS_PORT2_MAC); // R5
         led_select_low <= led_select_low_nxt; // R8
         led_select_high <= led_select_high_nxt; // R9
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // packs the control fields into their byte; bits 7 and 0 are
   // reserved and always read zero
   function [7:0] lplc_image;
      input pwr;
      input errdrop;
      input tst;
      input [1:0] pos;
      input led;
      begin
         lplc_image = 8'h00;
         lplc_image[`OLGC_BIT_PWR] = pwr;
         lplc_image[`OLGC_BIT_ERRDROP] = errdrop;
         lplc_image[`OLGC_BIT_TEST] = tst;
         lplc_image[`OLGC_BIT_POS_HI:`OLGC_BIT_POS_LO] = pos;
         lplc_image[`OLGC_BIT_LED] = led;
      end
   endfunction

   // ---------------------------------------------------------------
   // register read path
   // ---------------------------------------------------------------
   // read data is one cycle late; unmapped offsets read as zero
   always @* begin
      reg_rdata_nxt = 8'h00;
      case (reg_addr)
         `OLGC_ADDR_FTCB: begin
            reg_rdata_nxt = factory_test_b;
         end
         `OLGC_ADDR_LPLC: begin
            reg_rdata_nxt = lplc_image(phy_low_power_enable,
               error_drop_enable, test_mode, loopback_position_select,
               led_select_low);
         end
         default: begin
            reg_rdata_nxt = 8'h00;
         end
      endcase
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata <= reg_rdata_nxt;
         end
      end
   end

   // ---------------------------------------------------------------
   // per-frame loop or drop decision
   // ---------------------------------------------------------------
   // flags are only looked at in the frame_end cycle; the datapath
   // must present them there, anything outside that cycle is ignored
   always @* begin
      frame_bad = frame_crc_err | frame_undersize | frame_oversize;
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         frame_loop <= 1'b0;
         frame_drop <= 1'b0;
      end else begin
         frame_loop <= 1'b0;
         frame_drop <= 1'b0;
         if (frame_end) begin
            if (frame_is_oam) begin
               frame_drop <= 1'b1; // R2
            end else if (error_drop_enable && frame_bad) begin
               frame_drop <= 1'b1; // R2
            end else if (error_drop_enable) begin
               frame_loop <= 1'b1; // R3
            end else begin
               // errored frames still loop in this mode
               frame_loop <= 1'b1; // R4
            end
         end
      end
   end

endmodule // olgc_top

// ---- tb/olgc_props_properties.sv ----
// Purpose: concurrent checks on the control register slice
// Assumes: one clock, reset active low
// Notes: bound to the top module
`timescale 1ns/1ps
module olgc_props (
   input wire clk_sys,
   input wire rst_n,
   input wire reg_wr_en,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire frame_end,
   input wire frame_is_oam,
   input wire frame_crc_err,
   input wire frame_undersize,
   input wire frame_oversize,
   input wire frame_loop,
   input wire frame_drop,
   input wire phy_low_power_enable,
   input wire error_drop_enable,
   input wire [1:0] loopback_position_select,
   input wire loopback_at_port2_mac,
   input wire led_select_low,
   input wire led_select_high
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   wire bad = frame_crc_err | frame_undersize | frame_oversize;
   wire wr_ctl = reg_wr_en && reg_addr == 8'h0b;
   wire fe_eth = frame_end && !frame_is_oam;
   property p_pwr;
      wr_ctl |=> phy_low_power_enable == $past(reg_wdata[6]);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power save bit");
   property p_oam;
      frame_end && frame_is_oam |=> frame_drop && !frame_loop;
   endproperty
   a_oam: assert property (p_oam) else $error("oam frame kept");
   property p_err;
      fe_eth && error_drop_enable && bad |=> frame_drop && !frame_loop;
   endproperty
   a_err: assert property (p_err) else $error("bad frame kept");
   property p_good;
      fe_eth && !bad |=> frame_loop && !frame_drop;
   endproperty
   a_good: assert property (p_good) else $error("good frame lost");
   property p_keep;
      fe_eth && !error_drop_enable |=> frame_loop && !frame_drop;
   endproperty
   a_keep: assert property (p_keep) else $error("frame not looped");
   property p_pos;
      (loopback_position_select == 2'h2) [*3] |-> loopback_at_port2_mac;
   endproperty
   a_pos: assert property (p_pos) else $error("port2 position");
   property p_led;
      wr_ctl |=> led_select_low == $past(reg_wdata[1]);
   endproperty
   a_led: assert property (p_led) else $error("led low bit");
   property p_ledh;
      $past(rst_n, 3) |-> $stable(led_select_high);
   endproperty
   a_ledh: assert property (p_ledh) else $error("led high moved");
   c_drop: cover property (fe_eth && bad && error_drop_enable);
   c_loop: cover property (fe_eth && bad && !error_drop_enable);
   c_wr: cover property (wr_ctl);
endmodule // olgc_props
bind olgc_top olgc_props olgc_props_i (.clk_sys, .rst_n, .reg_wr_en,
   .reg_addr, .reg_wdata, .frame_end, .frame_is_oam, .frame_crc_err,
   .frame_undersize, .frame_oversize, .frame_loop, .frame_drop,
   .phy_low_power_enable, .error_drop_enable, .loopback_position_select,
   .loopback_at_port2_mac, .led_select_low, .led_select_high);

// ---- tb/olgc_host.sv ----
// Purpose: management host on the register port
// Assumes: requests change at falling edges only
// Notes: released address and data show inverted last value
`timescale 1ns/1ps
module olgc_host (
   input wire clk_sys,
   output logic reg_wr_en = 1'h0,
   output logic reg_rd_en = 1'h0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   input wire [7:0] reg_rdata,
   input wire reg_rvalid
);
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      reg_wr_en = 1'h1;
      reg_addr = a;
      // test bit kept 0, position kept at the only legal code
      reg_wdata = (a == 8'h0b) ? ((v & 8'he3) | 8'h08) : v;
      @(negedge clk_sys);
      reg_wr_en = 1'h0;
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
      output logic v);
      @(negedge clk_sys);
      reg_rd_en = 1'h1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd_en = 1'h0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
   endtask
endmodule // olgc_host

// ---- tb/olgc_top_tb_top.sv ----
// Purpose: self-checking bench for the control register slice
// Assumes: straps fixed for the whole run
// Notes: inputs change at falling edges
`timescale 1ns/1ps
module olgc_top_tb_top;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic wr, rd, rv, fe, oam, crc, und, ovr, fl, fd, pwr, ed, tm, p2, ll, lh;
   logic [7:0] addr, wd, rdat, ftb, d;
   logic [1:0] pos;
   int err_total = 0;
   int samples_checked = 0;
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   olgc_host olgc_host_i (.clk_sys(clk_sys), .reg_wr_en(wr), .reg_rd_en(rd),
      .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv));
   olgc_top olgc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(wr),
      .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
      .reg_rvalid(rv), .error_drop_strap_pin(1'h1),
      .loopback_position_strap_pin(1'h0), .led_select_high_strap_pin(1'h1),
      .frame_end(fe), .frame_is_oam(oam), .frame_crc_err(crc),
      .frame_undersize(und), .frame_oversize(ovr), .frame_loop(fl),
      .frame_drop(fd), .phy_low_power_enable(pwr), .error_drop_enable(ed),
      .test_mode(tm), .loopback_position_select(pos),
      .loopback_at_port2_mac(p2), .led_select_low(ll), .led_select_high(lh),
      .factory_test_b(ftb));
   task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
         err_total++;
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic v;
      olgc_host_i.rd(a, d, v);
      chk("rvalid", 8'h01, {7'h00, v});
      chk("rdata", e, d);
   endtask
   // f is {oam, crc, undersize, oversize}
   task automatic frm(input logic [3:0] f, input logic drop);
      @(negedge clk_sys);
      {fe, oam, crc, und, ovr} = {1'h1, f};
      @(negedge clk_sys);
      {fe, oam, crc, und, ovr} = 5'h00;
      chk("frame", {6'h00, drop, ~drop}, {6'h00, fd, fl});
   endtask
   task automatic t_reset;
      rdchk(8'h0b, 8'h28);
      rdchk(8'h0a, 8'h24);
      rdchk(8'h3f, 8'h00);
      chk("misc", 8'h0a, {4'h0, p2, tm, pos});
      chk("led_hi", 8'h01, {7'h00, lh});
   endtask
   task automatic t_write;
      olgc_host_i.wr(8'h0b, 8'h42);
      olgc_host_i.wr(8'h0a, 8'h5a);
      chk("fields", 8'h0b, {4'h0, pwr, ed, ll, lh});
      chk("ftb", 8'h5a, ftb);
      rdchk(8'h0b, 8'h4a);
   endtask
   task automatic t_frames;
      frm(4'h4, 1'h0);
      frm(4'h8, 1'h1);
      frm(4'h1, 1'h0);
      olgc_host_i.wr(8'h0b, 8'h20);
      chk("pwr_ed", 8'h01, {6'h00, pwr, ed});
      frm(4'h4, 1'h1);
      frm(4'h2, 1'h1);
      frm(4'h1, 1'h1);
      frm(4'h8, 1'h1);
      frm(4'h0, 1'h0);
   endtask
   // mid-run reset: straps must be taken again, writes undone
   task automatic t_rereset;
      olgc_host_i.wr(8'h0b, 8'h00);
      chk("ed_cleared", 8'h00, {7'h00, ed});
      @(negedge clk_sys);
      rst_n = 1'h0;
      repeat (3) @(negedge clk_sys);
      chk("ftb_in_reset", 8'h24, ftb);
      chk("lh_in_reset", 8'h00, {7'h00, lh});
      rst_n = 1'h1;
      repeat (3) @(negedge clk_sys);
      rdchk(8'h0b, 8'h28);
      chk("ftb_after", 8'h24, ftb);
      chk("led_hi_again", 8'h01, {7'h00, lh});
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      {fe, oam, crc, und, ovr} = 5'h00;
      repeat (12) @(negedge clk_sys);
      rst_n = 1'h1;
      repeat (3) @(negedge clk_sys);
      t_reset();
      t_write();
      t_frames();
      t_rereset();
      report_and_stop();
   end
   // run needs about 56 cycles
   initial begin
      #20000;
      err_total++;
      report_and_stop();
   end
endmodule // olgc_top_tb_top
